// ===== pkg/cfts_pkg.sv
package cfts_pkg;

    // Timing, in microseconds, at a 100 MHz clock
    localparam int CLK_MHZ            = 100;
    localparam int STARTUP_US         = 100;
    localparam int CLIM_HOLD_US       = 1000;
    localparam int IN_LOW_QUAL_US     = 10;
    localparam int IN_HIGH_QUAL_US    = 10;
    localparam int STARTUP_CYC        = STARTUP_US * CLK_MHZ;
    localparam int CLIM_HOLD_CYC      = CLIM_HOLD_US * CLK_MHZ;
    localparam int IN_LOW_QUAL_CYC    = IN_LOW_QUAL_US * CLK_MHZ;
    localparam int IN_HIGH_QUAL_CYC   = IN_HIGH_QUAL_US * CLK_MHZ;
    localparam int CNT_W              = 20;

    // AXI4-Lite register map
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_IRQ_ST  = 8'h08;
    localparam logic [7:0] REG_IRQ_MSK = 8'h0C;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Event bit positions, shared by status-sticky and mask registers
    localparam int EV_IN_LOW   = 0;
    localparam int EV_IN_HIGH  = 1;
    localparam int EV_OUT_LOW  = 2;
    localparam int EV_OUT_HIGH = 3;
    localparam int EV_CLIM     = 4;
    localparam int EV_W        = 5;

    // CTRL bit: software turn-off request (ANDed with turn-on pin)
    localparam int CTRL_SW_OFF = 0;

    typedef enum logic [2:0] {
        CFTS_WAIT_PWR = 3'h0,
        CFTS_STARTUP  = 3'h1,
        CFTS_IDLE     = 3'h3,
        CFTS_RUN      = 3'h2,
        CFTS_FLT_LOW  = 3'h6,
        CFTS_FLT_HIGH = 3'h7,
        CFTS_FLT_OUT  = 3'h5
    } cfts_state_t;

    // Synchronised analog comparisons
    typedef struct packed {
        logic in_valid;
        logic in_above_low_fall;
        logic in_above_low_rise;
        logic in_above_high_rise;
        logic in_above_high_fall;
        logic out_below_low;
        logic out_above_high;
        logic over_limit;
        logic adj_above_off;
        logic adj_below_on;
        logic adj_above_nominal;
        logic turn_on;
    } cfts_cmp_t;

    typedef struct packed {
        cfts_state_t      st;
        cfts_cmp_t        s1;
        cfts_cmp_t        s2;
        cfts_cmp_t        s3;
        cfts_cmp_t        v;
        logic [CNT_W-1:0] boot_cnt;
        logic [CNT_W-1:0] clim_cnt;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic             adj_latched;
        logic             adj_mode;
        logic             run;
        logic             fault_ind;
        logic             clim_act;
        logic             clim_reduced;
        logic             ovp_latch;
        logic [31:0]      ctrl;
        logic [EV_W-1:0]  irq_st;
        logic [EV_W-1:0]  irq_msk;
        logic             irq;
        logic             aw_ok;
        logic [7:0]       aw_addr;
        logic             w_ok;
        logic [31:0]      w_data;
        logic             aw_rdy;
        logic             w_rdy;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } cfts_reg_t;

endpackage

// ===== src/cfts_seq.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// How it works
// - After power valid, wait startup delay, then sample adjust pin once.
// - Sample above off level: latch adjust disabled, nominal setpoint.
// - Host holds adjust low at power-up; device latches adjust mode on.
// - Adjust mode survives faults and turn-off; only power loss clears it.
// - Current limit engages only after over-limit holds for 1 ms.
// - Limit typically 120% (100-143%); reduced when adjusted above nominal.
// - Current limit may last; output-low level forces shutdown fault.
// - While stopped, turn-on ignored until input above falling low level.
// - Running input below falling low level registers fault, stops stage.
// - Input dips shorter than low qualify time are not detected.
// - After input-low fault, restart when above rising level and on.
// - Input above rising high level registers fault, stops switching.
// - After input-high fault, restart below falling high level if on.
// - Fast overvoltage stops switching at once; resumes if brief.
// - Overvoltage past high qualify time registers fault, running or not.
// - Low turn-on pin disables; floating pin reads high and enables.
// - Fault indicator active whenever stage stops, idle when running.
// - Output overvoltage latched until turn-on drops or power is lost.
module cfts_seq #(
    parameter int STARTUP_CYCLES   = cfts_pkg::STARTUP_CYC,
    parameter int CLIM_HOLD_CYCLES = cfts_pkg::CLIM_HOLD_CYC,
    parameter int IN_LOW_CYCLES    = cfts_pkg::IN_LOW_QUAL_CYC,
    parameter int IN_HIGH_CYCLES   = cfts_pkg::IN_HIGH_QUAL_CYC
) (
    // Clock and reset
    input  wire logic               REF_CLK,
    input  wire logic               NRST,
    // Comparator and pin inputs
    input  wire cfts_pkg::cfts_cmp_t CMP,
    // Power stage and indicator
    output logic                    SWITCH_EN,
    output logic                    FAULT_IND,
    output logic                    ADJ_MODE,
    output logic                    CLIM_ACTIVE,
    output logic                    CLIM_REDUCED,
    output logic                    IRQ,
    // AXI4-Lite slave
    input  wire logic [7:0]         AWADDR,
    input  wire logic               AWVALID,
    output logic                    AWREADY,
    input  wire logic [31:0]        WDATA,
    input  wire logic [3:0]         WSTRB,
    input  wire logic               WVALID,
    output logic                    WREADY,
    output logic [1:0]              BRESP,
    output logic                    BVALID,
    input  wire logic               BREADY,
    input  wire logic [7:0]         ARADDR,
    input  wire logic               ARVALID,
    output logic                    ARREADY,
    output logic [31:0]             RDATA,
    output logic [1:0]              RRESP,
    output logic                    RVALID,
    input  wire logic               RREADY
);
    import cfts_pkg::*;

    localparam logic [CNT_W-1:0] BOOT_N = CNT_W'(STARTUP_CYCLES);
    localparam logic [CNT_W-1:0] CLIM_N = CNT_W'(CLIM_HOLD_CYCLES);
    localparam logic [CNT_W-1:0] LOW_N  = CNT_W'(IN_LOW_CYCLES);
    localparam logic [CNT_W-1:0] HIGH_N = CNT_W'(IN_HIGH_CYCLES);

    cfts_reg_t q;
    cfts_reg_t d;
    logic      on_req;
    logic      in_low;
    logic      in_high;
    logic      low_qual;
    logic      high_qual;
    logic [EV_W-1:0] ev;
    logic [7:0] wa;

    always_comb begin
        d = q;
        ev = '0;
        // Synchroniser, input counts once stages two and three agree
        d.s1 = CMP;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < $bits(cfts_cmp_t); i++) begin
            d.v[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.v[i];
        end

        // Turn-on pin high (pulled up when floating) and no soft-off
        on_req  = q.v.turn_on && !q.ctrl[CTRL_SW_OFF];
        in_low  = !q.v.in_above_low_fall;
        in_high = q.v.in_above_high_rise;

        // Qualification counters; short dips never reach the limit
        d.low_cnt  = in_low ? ((q.low_cnt < LOW_N) ? q.low_cnt + 1'b1
                                                    : q.low_cnt) : '0;
        d.high_cnt = in_high ? ((q.high_cnt < HIGH_N) ? q.high_cnt + 1'b1
                                                       : q.high_cnt) : '0;
        low_qual  = (q.low_cnt >= LOW_N);
        high_qual = (q.high_cnt >= HIGH_N);

        // Output overvoltage latch, cleared by turn-off or power loss
        if (q.run && q.v.out_above_high) begin
            d.ovp_latch = 1'b1;
            ev[EV_OUT_HIGH] = 1'b1;
        end else if (!on_req) begin
            d.ovp_latch = 1'b0;
        end

        // Current limit hold-off of 1 ms before engaging
        if (q.run && q.v.over_limit) begin
            d.clim_cnt = (q.clim_cnt < CLIM_N) ? q.clim_cnt + 1'b1 : q.clim_cnt;
        end else begin
            d.clim_cnt = '0;
        end
        d.clim_act = q.run && q.v.over_limit && (q.clim_cnt >= CLIM_N);
        if (d.clim_act && !q.clim_act) begin
            ev[EV_CLIM] = 1'b1;
        end
        // Lower the limit when adjusted above nominal setpoint
        d.clim_reduced = q.adj_mode && q.v.adj_above_nominal;

        case (q.st)
            CFTS_WAIT_PWR: begin
                d.run = 1'b0;
                d.boot_cnt = '0;
                if (q.v.in_valid && q.v.in_above_low_rise) begin
                    d.st = CFTS_STARTUP;
                end
            end
            CFTS_STARTUP: begin
                d.boot_cnt = q.boot_cnt + 1'b1;
                if (q.boot_cnt >= BOOT_N) begin
                    // Single sample; pulled-up pin means nominal setpoint
                    d.adj_latched = 1'b1;
                    d.adj_mode = q.v.adj_below_on && !q.v.adj_above_off;
                    d.st = CFTS_IDLE;
                end
            end
            CFTS_IDLE: begin
                // Turn-on ignored while input still low
                if (on_req && !in_low && !q.ovp_latch
                        && !q.v.in_above_high_rise) begin
                    d.st = CFTS_RUN;
                end
                if (high_qual) begin  // Registered even when stopped
                    ev[EV_IN_HIGH] = 1'b1;
                    d.st = CFTS_FLT_HIGH;
                end
            end
            CFTS_RUN: begin
                if (!on_req) begin
                    d.st = CFTS_IDLE;
                end else if (low_qual) begin
                    ev[EV_IN_LOW] = 1'b1;
                    d.st = CFTS_FLT_LOW;
                end else if (high_qual) begin
                    ev[EV_IN_HIGH] = 1'b1;
                    d.st = CFTS_FLT_HIGH;
                end else if (q.v.out_below_low || q.v.out_above_high) begin
                    // Current limit alone never stops the stage
                    ev[EV_OUT_LOW] = q.v.out_below_low;
                    d.st = CFTS_FLT_OUT;
                end
            end
            CFTS_FLT_LOW: begin
                if (q.v.in_above_low_rise) begin
                    d.st = CFTS_IDLE;
                end
            end
            CFTS_FLT_HIGH: begin
                if (!q.v.in_above_high_fall) begin
                    d.st = CFTS_IDLE;
                end
            end
            CFTS_FLT_OUT: begin
                // Output-low retries through idle; overvoltage holds latch
                d.st = CFTS_IDLE;
            end
            default: d.st = CFTS_WAIT_PWR;
        endcase

        // Fast overvoltage gate stops switching at once, no fault yet
        d.run = (d.st == CFTS_RUN) && !in_high && q.v.in_valid;
        // Indicator active whenever the stage is stopped
        d.fault_ind = !d.run;

        // Loss of input power clears state, adjust mode and overvoltage latch; CTRL and event status kept
        if (!q.v.in_valid) begin
            d.st = CFTS_WAIT_PWR;
            d.adj_latched = 1'b0;
            d.adj_mode = 1'b0;
            d.ovp_latch = 1'b0;
            d.run = 1'b0;
            d.fault_ind = 1'b1;
        end

        // AXI4-Lite write: address and data in either order
        if (AWVALID && !q.aw_ok && !q.bvalid) begin
            d.aw_ok = 1'b1;
            d.aw_addr = AWADDR;
        end
        if (WVALID && !q.w_ok && !q.bvalid) begin
            d.w_ok = 1'b1;
            d.w_data = WDATA;
        end
        wa = q.aw_addr;
        // Hardware set wins over write-one-to-clear
        d.irq_st = q.irq_st;
        if (q.aw_ok && q.w_ok && !q.bvalid) begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (wa)
                REG_CTRL:    d.ctrl = q.w_data;
                REG_IRQ_ST:  d.irq_st = q.irq_st & ~q.w_data[EV_W-1:0];
                REG_IRQ_MSK: d.irq_msk = q.w_data[EV_W-1:0];
                REG_STATUS:  d.bresp = RESP_OKAY;
                default:     d.bresp = RESP_SLVERR;
            endcase
        end
        d.irq_st = d.irq_st | ev;
        if (q.bvalid && BREADY) begin
            d.bvalid = 1'b0;
        end
        d.aw_rdy = !d.aw_ok && !d.bvalid;
        d.w_rdy  = !d.w_ok && !d.bvalid;
        d.irq = |(d.irq_st & d.irq_msk);

        // AXI4-Lite read, one at a time
        d.arready = ARVALID && !q.arready && !q.rvalid;
        if (q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            case (ARADDR)
                REG_CTRL:    d.rdata = q.ctrl;
                REG_STATUS:  d.rdata = {23'h000000, q.ovp_latch, q.clim_act,
                                        q.adj_latched, q.adj_mode, q.run,
                                        q.fault_ind, q.st};
                REG_IRQ_ST:  d.rdata = {27'h0000000, q.irq_st};
                REG_IRQ_MSK: d.rdata = {27'h0000000, q.irq_msk};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && RREADY) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            q <= '0;
            q.fault_ind <= 1'b1;
            q.aw_rdy <= 1'b1;
            q.w_rdy <= 1'b1;
            q.st <= CFTS_WAIT_PWR;
        end else begin
            q <= d;
        end
    end

    assign SWITCH_EN    = q.run;
    assign FAULT_IND    = q.fault_ind;
    assign ADJ_MODE     = q.adj_mode;
    assign CLIM_ACTIVE  = q.clim_act;
    assign CLIM_REDUCED = q.clim_reduced;
    assign IRQ          = q.irq;
    assign AWREADY      = q.aw_rdy;
    assign WREADY       = q.w_rdy;
    assign BVALID       = q.bvalid;
    assign BRESP        = q.bresp;
    assign ARREADY      = q.arready;
    assign RVALID       = q.rvalid;
    assign RDATA        = q.rdata;
    assign RRESP        = q.rresp;

    property p_ind_run;
        @(posedge REF_CLK) disable iff (!NRST) q.run |-> !q.fault_ind;
    endproperty
    a_ind_run: assert property (p_ind_run) else $error("indicator on while running");

    property p_clim_hold;
        @(posedge REF_CLK) disable iff (!NRST)
            $rose(q.clim_act) |-> $past(q.clim_cnt) >= CLIM_N;
    endproperty
    a_clim_hold: assert property (p_clim_hold) else $error("limit engaged early");

    property p_adj_keep;
        @(posedge REF_CLK) disable iff (!NRST)
            q.adj_latched && q.v.in_valid |=> $stable(q.adj_mode);
    endproperty
    a_adj_keep: assert property (p_adj_keep) else $error("adjust mode changed");

    property p_no_start_low;
        @(posedge REF_CLK) disable iff (!NRST)
            $rose(q.run) |-> $past(q.v.in_above_low_fall);
    endproperty
    a_no_start_low: assert property (p_no_start_low) else $error("started on low input");

    property p_high_stop;
        @(posedge REF_CLK) disable iff (!NRST)
            q.v.in_above_high_rise |=> !q.run;
    endproperty
    a_high_stop: assert property (p_high_stop) else $error("ran during overvoltage");

    property p_ovp_block;
        @(posedge REF_CLK) disable iff (!NRST) q.ovp_latch |=> !q.run;
    endproperty
    a_ovp_block: assert property (p_ovp_block) else $error("restart with latch set");

    property p_off_stop;
        @(posedge REF_CLK) disable iff (!NRST)
            !q.v.turn_on |=> !q.run;
    endproperty
    a_off_stop: assert property (p_off_stop) else $error("ran while turned off");

    property p_low_fault;
        @(posedge REF_CLK) disable iff (!NRST)
            q.st == CFTS_RUN && q.low_cnt >= LOW_N && on_req && q.v.in_valid
            |=> q.st == CFTS_FLT_LOW;
    endproperty
    a_low_fault: assert property (p_low_fault) else $error("input-low not registered");

    property p_adj_sample;
        @(posedge REF_CLK) disable iff (!NRST)
            $rose(q.adj_latched) |-> $past(q.boot_cnt) >= BOOT_N;
    endproperty
    a_adj_sample: assert property (p_adj_sample)
        else $error("adjust sampled early");

    property p_adj_val;
        @(posedge REF_CLK) disable iff (!NRST)
            $rose(q.adj_latched) |-> q.adj_mode ==
                $past(q.v.adj_below_on && !q.v.adj_above_off);
    endproperty
    a_adj_val: assert property (p_adj_val)
        else $error("adjust mode wrong");

    property p_clim_red;
        @(posedge REF_CLK) disable iff (!NRST)
            q.adj_mode && q.v.adj_above_nominal |=> q.clim_reduced;
    endproperty
    a_clim_red: assert property (p_clim_red)
        else $error("limit not lowered");

    property p_out_low;
        @(posedge REF_CLK) disable iff (!NRST)
            q.run && q.v.out_below_low |=> !q.run;
    endproperty
    a_out_low: assert property (p_out_low)
        else $error("ran below output-low level");

    property p_low_wait;
        @(posedge REF_CLK) disable iff (!NRST)
            q.st == CFTS_FLT_LOW && !q.v.in_above_low_rise
            |=> q.st != CFTS_IDLE;
    endproperty
    a_low_wait: assert property (p_low_wait)
        else $error("left input-low fault early");

    property p_high_wait;
        @(posedge REF_CLK) disable iff (!NRST)
            q.st == CFTS_FLT_HIGH && q.v.in_above_high_fall
            |=> q.st != CFTS_IDLE;
    endproperty
    a_high_wait: assert property (p_high_wait)
        else $error("left input-high fault early");

    property p_high_qual;
        @(posedge REF_CLK) disable iff (!NRST)
            q.st == CFTS_IDLE && high_qual && q.v.in_valid
            |=> q.st == CFTS_FLT_HIGH;
    endproperty
    a_high_qual: assert property (p_high_qual)
        else $error("idle overvoltage missed");

    property p_set_wins;
        @(posedge REF_CLK) disable iff (!NRST)
            |ev |=> (q.irq_st & $past(ev)) == $past(ev);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost");

endmodule

// ===== tb/cfts_host_model.sv
`timescale 1ns/1ns
module cfts_host_model (
    // Clock and bench requests
    input  wire logic       clk,
    input  wire logic       en_req,
    input  wire logic       trim_req,
    input  wire logic       trim_up,
    // Device pins
    input  wire logic       fault_ind,
    output logic            turn_on,
    output logic            adj_below_on,
    output logic            adj_above_off,
    output logic            adj_above_nominal,
    output logic [7:0]      fault_cnt
);
    logic fault_last;
    initial begin
        turn_on = 1'b1;
        adj_below_on = 1'b0;
        adj_above_off = 1'b1;
        adj_above_nominal = 1'b0;
        fault_cnt = 8'h00;
        fault_last = 1'b1;
    end
    // Pins change only just after an edge, like real host logic
    always @(posedge clk) begin
        turn_on <= en_req;
        adj_below_on <= trim_req;
        adj_above_off <= !trim_req;
        adj_above_nominal <= trim_up;
        fault_last <= fault_ind;
        if (fault_ind && !fault_last) begin
            fault_cnt <= fault_cnt + 8'h01;
        end
    end
endmodule

// ===== tb/cfts_seq_tb_top.sv
`timescale 1ns/1ns
module cfts_seq_tb_top;
    import cfts_pkg::*;
    localparam int ST_C = 20;
    localparam int CL_C = 30;
    localparam int LQ_C = 8;
    localparam int HQ_C = 8;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    cfts_cmp_t   cmp_q = '0;
    cfts_cmp_t   cmp;
    logic        en_req = 1'b1;
    logic        trim_req = 1'b1;
    logic        trim_up = 1'b0;
    logic        h_on, h_bel, h_off, h_nom;
    logic [7:0]  fault_cnt, fc;
    logic        sw, flt, adj, clim, clim_red, irq;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] d;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata;
    int          bad_count = 0;
    int          checks_done = 0;
    int          seed = 32'h7f23495b;
    int          n;

    always #5 clk = ~clk;
    always_comb begin
        cmp = cmp_q;
        cmp.turn_on = h_on;
        cmp.adj_below_on = h_bel;
        cmp.adj_above_off = h_off;
        cmp.adj_above_nominal = h_nom;
    end

    cfts_seq #(.STARTUP_CYCLES(ST_C), .CLIM_HOLD_CYCLES(CL_C),
        .IN_LOW_CYCLES(LQ_C), .IN_HIGH_CYCLES(HQ_C)) u_dut (
        .REF_CLK(clk), .NRST(nrst), .CMP(cmp), .SWITCH_EN(sw),
        .FAULT_IND(flt), .ADJ_MODE(adj), .CLIM_ACTIVE(clim),
        .CLIM_REDUCED(clim_red), .IRQ(irq), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
    cfts_host_model u_host (.clk(clk), .en_req(en_req),
        .trim_req(trim_req), .trim_up(trim_up), .fault_ind(flt),
        .turn_on(h_on), .adj_below_on(h_bel), .adj_above_off(h_off),
        .adj_above_nominal(h_nom), .fault_cnt(fault_cnt));

    function automatic logic exp_adj(input logic bel, input logic off);
        return bel && !off;
    endfunction

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic ck(input string nm, input logic s, input logic e);
        chk(nm, {31'h0, s}, {31'h0, e});
    endtask
    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Bounded wait; the caller compares afterwards
    task automatic ws(input logic v, input int lim);
        for (int i = 0; i < lim && sw !== v; i++) @(posedge clk);
    endtask
    task automatic hold(input string nm, input logic v, input int k);
        logic ok;
        ok = 1'b1;
        repeat (k) begin
            @(posedge clk);
            if (sw !== v) ok = 1'b0;
        end
        ck(nm, ok, 1'b1);
    endtask
    task automatic set_in(input logic [4:0] b);
        {cmp_q.in_valid, cmp_q.in_above_low_fall, cmp_q.in_above_low_rise,
         cmp_q.in_above_high_rise, cmp_q.in_above_high_fall} <= b;
    endtask
    // Leading edge keeps a strobe from being driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rk(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
        rd(a, d, r);
        chk(nm, d & m, e);
        chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    initial begin
        cyc(2);
        nrst <= 1'b1;
        @(posedge clk);
        ck("sw_rst", sw, 1'b0);
        ck("flt_rst", flt, 1'b1);
        rk("msk_rst", REG_IRQ_MSK, 32'hFFFFFFFF, 32'h0);
        rd(8'h10, d, r);
        chk("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(8'h10, 32'h0, r);
        chk("bresp_bad", {30'h0, r}, {30'h0, RESP_SLVERR});
        d = $random(seed);
        wr(REG_IRQ_MSK, d, r);
        chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
        rk("msk", REG_IRQ_MSK, 32'hFFFFFFFF, d & 32'h1F);
        wr(REG_IRQ_MSK, 32'h1F, r);
        set_in(5'b11100);
        cyc(10);
        ck("early", sw, 1'b0);
        ws(1'b1, ST_C + 40);
        ck("start", sw, 1'b1);
        ck("adj_on", adj, exp_adj(1'b1, 1'b0));
        ck("flt_run", flt, 1'b0);
        rk("status", REG_STATUS, 32'h7F, {25'h0, 4'hE, CFTS_RUN});
        trim_req <= 1'b0;
        trim_up <= 1'b1;
        cyc(12);
        ck("adj_once", adj, 1'b1);
        ck("clim_red", clim_red, 1'b1);
        trim_up <= 1'b0;
        cyc(12);
        ck("clim_nom", clim_red, 1'b0);
        repeat (3) begin
            n = 3 + ($unsigned($random(seed)) % (CL_C - 10));
            cmp_q.over_limit <= 1'b1;
            cyc(n);
            cmp_q.over_limit <= 1'b0;
            cyc(10);
            ck("clim_brief", clim, 1'b0);
        end
        cmp_q.over_limit <= 1'b1;
        cyc(CL_C - 2);
        ck("clim_hold", clim, 1'b0);
        for (int i = 0; i < 40 && clim !== 1'b1; i++) @(posedge clk);
        ck("clim_on", clim, 1'b1);
        hold("clim_sustain", 1'b1, 20);
        ck("irq_clim", irq, 1'b1);
        cmp_q.out_below_low <= 1'b1;
        ws(1'b0, 30);
        ck("out_low", sw, 1'b0);
        rk("st_out_low", REG_IRQ_ST, 32'h4, 32'h4);
        cmp_q.over_limit <= 1'b0;
        cmp_q.out_below_low <= 1'b0;
        cyc(8);
        ws(1'b1, 300);
        wr(REG_IRQ_ST, 32'h1F, r);
        cyc(3);
        ck("irq_clr", irq, 1'b0);
        repeat (4) begin
            n = 2 + ($unsigned($random(seed)) % (LQ_C - 4));
            set_in(5'b10000);
            hold("dip", 1'b1, n);
            set_in(5'b11100);
            hold("dip_after", 1'b1, 12);
        end
        set_in(5'b10000);
        ws(1'b0, LQ_C + 20);
        ck("in_low", sw, 1'b0);
        rk("st_in_low", REG_IRQ_ST, 32'h1, 32'h1);
        set_in(5'b11000);
        hold("low_wait", 1'b0, 20);
        set_in(5'b11100);
        ws(1'b1, 100);
        ck("low_restart", sw, 1'b1);
        ck("adj_keep", adj, 1'b1);
        wr(REG_IRQ_ST, 32'h1F, r);
        set_in(5'b11111);
        cyc(3);
        set_in(5'b11100);
        cyc(20);
        ws(1'b1, 40);
        ck("ov_brief", sw, 1'b1);
        rk("st_ov_brief", REG_IRQ_ST, 32'h2, 32'h0);
        set_in(5'b11111);
        cyc(HQ_C + 10);
        ck("in_high", sw, 1'b0);
        rk("st_in_high", REG_IRQ_ST, 32'h2, 32'h2);
        set_in(5'b11101);
        hold("high_wait", 1'b0, 20);
        set_in(5'b11100);
        ws(1'b1, 100);
        ck("high_restart", sw, 1'b1);
        fc = fault_cnt;
        en_req <= 1'b0;
        ws(1'b0, 20);
        ck("off", sw, 1'b0);
        cyc(5);
        ck("flt_off", flt, 1'b1);
        chk("flt_edges", {24'h0, fault_cnt}, {24'h0, fc + 8'h01});
        en_req <= 1'b1;
        ws(1'b1, 100);
        ck("on_again", sw, 1'b1);
        ck("adj_after_off", adj, 1'b1);
        wr(REG_CTRL, 32'h1, r);
        ws(1'b0, 20);
        ck("soft_off", flt, 1'b1);
        wr(REG_CTRL, 32'h0, r);
        ws(1'b1, 100);
        ck("soft_on", sw, 1'b1);
        cmp_q.out_above_high <= 1'b1;
        ws(1'b0, 20);
        ck("ovp", sw, 1'b0);
        cmp_q.out_above_high <= 1'b0;
        hold("ovp_latch", 1'b0, 30);
        en_req <= 1'b0;
        cyc(10);
        en_req <= 1'b1;
        ws(1'b1, 100);
        ck("ovp_clear", sw, 1'b1);
        en_req <= 1'b0;
        wr(REG_IRQ_ST, 32'h1F, r);
        set_in(5'b11111);
        cyc(HQ_C + 20);
        rk("st_idle_high", REG_IRQ_ST, 32'h2, 32'h2);
        ck("irq_set", irq, 1'b1);
        wr(REG_IRQ_MSK, 32'h0, r);
        cyc(3);
        ck("irq_mask", irq, 1'b0);
        set_in(5'b10000);
        cyc(10);
        en_req <= 1'b1;
        hold("ign_on", 1'b0, 30);
        set_in(5'b00000);
        cyc(20);
        ck("adj_lost", adj, 1'b0);
        set_in(5'b11100);
        ws(1'b1, ST_C + 100);
        ck("adj_off", adj, exp_adj(1'b0, 1'b1));
        ck("clim_off", clim_red, 1'b0);
        stop_test();
    end
endmodule
